/* rtl/gtw_timer.sv */
`timescale 1ns/10ps
package gtw_pkg;
  // clock and prescaler base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int CYC_PER_TICK = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 6;
  // field widths
  localparam int RES_W = 4;
  localparam int CNT_W = 16;
  localparam int PRE_W = 15;
  // control register layout, bit 31 is big-endian bit 0
  localparam int KEY_LSB = 24;
  localparam int EN_BIT = 23;
  localparam int RES_LSB = 16;
  localparam int RELOAD_LSB = 0;
  // byte enables: lane 0:7 is reg_be[3]
  localparam int LANE_KEY = 3;
  localparam int LANE_CFG = 2;
  localparam int LANE_RLD_HI = 1;
  localparam int LANE_RLD_LO = 0;
  localparam logic [3:0] BE_KEY_ONLY = 4'h8;
  // key patterns
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_FIRE = 8'haa;
  // register addresses
  localparam logic [1:0] ADDR_CTL1 = 2'h0;
  localparam logic [1:0] ADDR_STAT1 = 2'h1;
  localparam logic [1:0] ADDR_CTL2 = 2'h2;
  localparam logic [1:0] ADDR_STAT2 = 2'h3;
  // reset timing, seconds at chosen resolution
  localparam int T1_RESET_S = 8;
  localparam int T2_RESET_S = 16;
  localparam logic [3:0] T1_RESET_RES = 4'h7;
  localparam logic [3:0] T2_RESET_RES = 4'h8;
  localparam logic T_RESET_EN = 1'b1;
  localparam int T1_RESET_COUNT =
    T1_RESET_S * 1000000 / (1 << int'(T1_RESET_RES));
  localparam int T2_RESET_COUNT =
    T2_RESET_S * 1000000 / (1 << int'(T2_RESET_RES));
endpackage : gtw_pkg

////////////////////////////////////////////////////////////////////////////
module gtw_timer #(
  parameter logic [3:0] RESET_RES = 4'h0,
  parameter logic [15:0] RESET_COUNT = 16'h0001
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // base tick, one per microsecond
  input wire logic tick,
  // load from the control register
  input wire logic load,
  input wire logic load_en,
  input wire logic [3:0] load_res,
  input wire logic [15:0] load_count,
  // state
  output logic enabled,
  output logic [3:0] res,
  output logic [15:0] count,
  output logic expired
);

  logic [gtw_pkg::PRE_W-1:0] pre;
  logic pre_wrap;
  logic step;

  function automatic logic [gtw_pkg::PRE_W-1:0] pre_limit(
    input logic [3:0] r
  );
    logic [gtw_pkg::PRE_W:0] one_hot;
    one_hot = '0;
    one_hot[r] = 1'b1;
    pre_limit = one_hot[gtw_pkg::PRE_W-1:0] - 15'h0001;
  endfunction : pre_limit

  assign pre_wrap = (pre == pre_limit(res));
  assign step = enabled && tick && pre_wrap && (count != 16'h0000) && !load;

  always_ff @(posedge clk) begin
    if (rst) begin
      enabled <= gtw_pkg::T_RESET_EN;
      res <= RESET_RES;
    end else if (load) begin
      enabled <= load_en;
      res <= load_res;
    end
  end

  // a load restarts the prescaler, but the microsecond base keeps its
  // phase, so expiry can land up to one microsecond early
  always_ff @(posedge clk) begin
    if (rst || load) begin
      pre <= '0;
    end else if (enabled && tick) begin
      pre <= pre_wrap ? '0 : pre + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= RESET_COUNT;
    end else if (load) begin
      count <= load_count;
    end else if (step) begin
      count <= count - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else if (load) begin
      expired <= (load_count == 16'h0000);
    end else if (step) begin
      expired <= (count == 16'h0001);
    end
  end

endmodule : gtw_timer

/* rtl/gtw_top.sv */
// Functional notes
// - two identical timers, fully independent
// - reset loads eight and sixteen seconds
// - reload accepted at any moment
// - enabled timer decrements once per prescaler period
// - zero asserts expiry and holds count
// - prescaler power of two, 1 to 32768 us
// - expiry time is count times period, up to one microsecond early
// - control starts, stops, stores, reinitialises
// - status read returns live count
// - arm only with key lane alone, first pattern
// - arming write leaves timer untouched
// - second write needs key lane, second pattern
// - config lane picks bus or stored field
// - both reload lanes pick bus or stored
// - any following write to the same control register disarms
// - reads never disturb arming
`timescale 1ns/10ps
module gtw_top #(
  parameter logic [15:0] T1_COUNT = 16'(gtw_pkg::T1_RESET_COUNT),
  parameter logic [15:0] T2_COUNT = 16'(gtw_pkg::T2_RESET_COUNT)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control register space
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [1:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // expiry outputs
  output logic first_guard_timer_expired,
  output logic second_guard_timer_expired
);

  localparam logic [3:0] RESET_RES [2] =
    '{gtw_pkg::T1_RESET_RES, gtw_pkg::T2_RESET_RES};
  localparam logic [15:0] RESET_COUNT [2] = '{T1_COUNT, T2_COUNT};

  logic [gtw_pkg::TICK_CNT_W-1:0] tick_cnt;
  logic tick;
  logic [7:0] key;
  logic cfg_lane;
  logic rld_lanes;
  logic [1:0] wr_ctl;
  logic [1:0] arm_ok;
  logic [1:0] fire;
  logic [1:0] armed;
  logic [1:0] en_field;
  logic [3:0] res_field [2];
  logic [15:0] reload_field [2];
  logic [1:0] tload;
  logic [1:0] ld_en;
  logic [3:0] ld_res [2];
  logic [15:0] ld_cnt [2];
  logic [1:0] tmr_en;
  logic [3:0] tmr_res [2];
  logic [15:0] count [2];
  logic [1:0] expired;

  function automatic logic [1:0] ctl_addr(input int idx);
    ctl_addr = (idx == 0) ? gtw_pkg::ADDR_CTL1 : gtw_pkg::ADDR_CTL2;
  endfunction : ctl_addr

  function automatic logic [31:0] ctl_word(
    input logic en,
    input logic [3:0] r,
    input logic [15:0] rl
  );
    ctl_word = '0;
    ctl_word[gtw_pkg::EN_BIT] = en;
    ctl_word[gtw_pkg::RES_LSB +: gtw_pkg::RES_W] = r;
    ctl_word[gtw_pkg::RELOAD_LSB +: gtw_pkg::CNT_W] = rl;
  endfunction : ctl_word

  ////////////////////////////////////////////////////////////////////////////
  // microsecond base shared by both prescalers

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 6'(gtw_pkg::CYC_PER_TICK - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 6'h01;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key decode

  assign key = reg_wdata[gtw_pkg::KEY_LSB +: 8];
  assign cfg_lane = reg_be[gtw_pkg::LANE_CFG];
  assign rld_lanes = reg_be[gtw_pkg::LANE_RLD_HI] &&
                     reg_be[gtw_pkg::LANE_RLD_LO];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_ctl[i] = reg_req && reg_wr && (reg_addr == ctl_addr(i));
      arm_ok[i] = wr_ctl[i] && !armed[i] &&
                  (reg_be == gtw_pkg::BE_KEY_ONLY) &&
                  (key == gtw_pkg::KEY_ARM);
      fire[i] = wr_ctl[i] && armed[i] && reg_be[gtw_pkg::LANE_KEY] &&
                (key == gtw_pkg::KEY_FIRE);
    end
  end

  // every valid second write reloads the timer in some form
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tload[i] = fire[i];
      ld_en[i] = cfg_lane ? reg_wdata[gtw_pkg::EN_BIT] : en_field[i];
      ld_res[i] = cfg_lane ?
        reg_wdata[gtw_pkg::RES_LSB +: gtw_pkg::RES_W] : res_field[i];
      ld_cnt[i] = rld_lanes ?
        reg_wdata[gtw_pkg::RELOAD_LSB +: gtw_pkg::CNT_W] :
        reload_field[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arming state; reads never reach it

  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctl[i]) begin
          armed[i] <= armed[i] ? 1'b0 : arm_ok[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored fields of the control registers

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        en_field[i] <= gtw_pkg::T_RESET_EN;
        res_field[i] <= RESET_RES[i];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fire[i] && cfg_lane) begin
          en_field[i] <= reg_wdata[gtw_pkg::EN_BIT];
          res_field[i] <=
            reg_wdata[gtw_pkg::RES_LSB +: gtw_pkg::RES_W];
        end
      end
    end
  end

  // a partial reload write would otherwise tear the 16-bit value
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        reload_field[i] <= RESET_COUNT[i];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fire[i] && rld_lanes) begin
          reload_field[i] <=
            reg_wdata[gtw_pkg::RELOAD_LSB +: gtw_pkg::CNT_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers

  for (genvar g = 0; g < 2; g++) begin : g_timer
    gtw_timer #(
      .RESET_RES(RESET_RES[g]),
      .RESET_COUNT(RESET_COUNT[g])
    ) u_timer (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .load(tload[g]),
      .load_en(ld_en[g]),
      .load_res(ld_res[g]),
      .load_count(ld_cnt[g]),
      .enabled(tmr_en[g]),
      .res(tmr_res[g]),
      .count(count[g]),
      .expired(expired[g])
    );
  end

  assign first_guard_timer_expired = expired[0];
  assign second_guard_timer_expired = expired[1];

  ////////////////////////////////////////////////////////////////////////////
  // read and acknowledge, one cycle after the request

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_ack <= 1'b0;
      reg_rdata <= '0;
    end else begin
      reg_ack <= reg_req;
      if (reg_req && !reg_wr) begin
        case (reg_addr)
          gtw_pkg::ADDR_CTL1:
            reg_rdata <= ctl_word(en_field[0], res_field[0], reload_field[0]);
          gtw_pkg::ADDR_STAT1: reg_rdata <= {16'h0000, count[0]};
          gtw_pkg::ADDR_CTL2:
            reg_rdata <= ctl_word(en_field[1], res_field[1], reload_field[1]);
          gtw_pkg::ADDR_STAT2: reg_rdata <= {16'h0000, count[1]};
          default: reg_rdata <= '0;
        endcase
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_reset_counts;
    @(posedge clk) $past(rst) |->
      count[0] == T1_COUNT && count[1] == T2_COUNT;
  endproperty
  a_reset_counts: assert property (p_reset_counts)
    else $error("reset counts wrong");

  property p_reset_clear;
    @(posedge clk) $past(rst) |-> armed == 2'b00 && expired == 2'b00;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left arm or expiry");

  property p_tick_spacing;
    @(posedge clk) disable iff (rst) tick |=> !tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("base tick too frequent");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    sequence s_arm;
      wr_ctl[g] && !armed[g] && reg_be == gtw_pkg::BE_KEY_ONLY &&
        key == gtw_pkg::KEY_ARM;
    endsequence

    sequence s_fire_full;
      fire[g] && cfg_lane && rld_lanes;
    endsequence

    property p_independent;
      @(posedge clk) disable iff (rst) wr_ctl[g] |-> !tload[1 - g];
    endproperty
    a_independent: assert property (p_independent)
      else $error("write reached the other timer");

    property p_decrement;
      @(posedge clk) disable iff (rst)
        !tload[g] ##1 count[g] != $past(count[g]) |->
          count[g] == $past(count[g]) - 16'h0001 && tmr_en[g];
    endproperty
    a_decrement: assert property (p_decrement)
      else $error("count moved other than by one");

    property p_hold_zero;
      @(posedge clk) disable iff (rst)
        expired[g] && !tload[g] |=> count[g] == 16'h0000 && expired[g];
    endproperty
    a_hold_zero: assert property (p_hold_zero)
      else $error("expired timer left zero");

    property p_arm_quiet;
      @(posedge clk) disable iff (rst)
        s_arm |=> armed[g] && $stable(res_field[g]) &&
          $stable(tmr_en[g]) && $stable(tmr_res[g]);
    endproperty
    a_arm_quiet: assert property (p_arm_quiet)
      else $error("arming write disturbed timer");

    property p_no_arm;
      @(posedge clk) disable iff (rst)
        wr_ctl[g] && !armed[g] && reg_be != gtw_pkg::BE_KEY_ONLY |=>
          !armed[g];
    endproperty
    a_no_arm: assert property (p_no_arm)
      else $error("armed with other lanes");

    property p_bad_fire;
      @(posedge clk) disable iff (rst)
        wr_ctl[g] && armed[g] && key != gtw_pkg::KEY_FIRE |=>
          $stable(reload_field[g]) && $stable(res_field[g]) &&
          $stable(en_field[g]) && !armed[g];
    endproperty
    a_bad_fire: assert property (p_bad_fire)
      else $error("bad second write took effect");

    property p_disarm;
      @(posedge clk) disable iff (rst) wr_ctl[g] && armed[g] |=> !armed[g];
    endproperty
    a_disarm: assert property (p_disarm)
      else $error("still armed after second write");

    property p_read_quiet;
      @(posedge clk) disable iff (rst) reg_req && !reg_wr |=> $stable(armed);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
      else $error("read changed arming");

    property p_full_load;
      @(posedge clk) disable iff (rst)
        s_fire_full |=> count[g] == $past(reg_wdata[15:0]) &&
          reload_field[g] == $past(reg_wdata[15:0]) &&
          tmr_res[g] == $past(reg_wdata[19:16]);
    endproperty
    a_full_load: assert property (p_full_load)
      else $error("full load mismatch");

    property p_stored_cfg;
      @(posedge clk) disable iff (rst)
        fire[g] && !cfg_lane |=> $stable(res_field[g]) &&
          tmr_res[g] == res_field[g] && tmr_en[g] == en_field[g];
    endproperty
    a_stored_cfg: assert property (p_stored_cfg)
      else $error("stored config not applied");

    property p_revive;
      @(posedge clk) disable iff (rst)
        tload[g] && ld_cnt[g] != 16'h0000 |=> !expired[g];
    endproperty
    a_revive: assert property (p_revive)
      else $error("reload left expiry set");

    property p_status;
      @(posedge clk) disable iff (rst)
        reg_req && !reg_wr && reg_addr == (g == 0 ? gtw_pkg::ADDR_STAT1 :
          gtw_pkg::ADDR_STAT2) |=>
          reg_ack && reg_rdata[15:0] == $past(count[g]);
    endproperty
    a_status: assert property (p_status)
      else $error("status read wrong");
  end

endmodule : gtw_top

/* verification/gtw_tb.sv */
`timescale 1ns/10ps
module dual_watchdog_timer_tb_top;
  localparam logic [15:0] RC = 16'h0005;
  logic clk;
  logic rst;
  logic reg_req;
  logic reg_wr;
  logic [1:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata;
  logic reg_ack;
  logic [31:0] reg_rdata;
  logic first_guard_timer_expired;
  logic second_guard_timer_expired;
  int error_cnt;
  int n_compared;
  logic [31:0] q;

  ////////////////////////////////////////////////////////////////////////////
  // short reset counts so that the default pair never expires in the run
  gtw_top #(.T1_COUNT(RC), .T2_COUNT(RC)) dut (
    .clk(clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_be(reg_be),
    .reg_wdata(reg_wdata),
    .reg_ack(reg_ack),
    .reg_rdata(reg_rdata),
    .first_guard_timer_expired(first_guard_timer_expired),
    .second_guard_timer_expired(second_guard_timer_expired)
  );

  initial begin
    clk = 1'b0;
  end
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] mk(input logic en, input logic [3:0] r,
                                     input logic [15:0] rl);
    return {8'h00, en, 3'h0, r, rl};
  endfunction : mk

  // one access; request held for exactly the taking edge
  task acc(input logic w, input logic [1:0] a, input logic [3:0] be,
           input logic [31:0] d);
    @(posedge clk);
    reg_req <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge clk);
    reg_req <= 1'b0;
    #1;
    chk({31'h0, reg_ack}, 32'h1);
    q = reg_rdata;
  endtask : acc

  task arm1;
    acc(1'b1, gtw_pkg::ADDR_CTL1, gtw_pkg::BE_KEY_ONLY, 32'h55000000);
  endtask : arm1

  // counts cycles until expiry of timer idx; expiry falls within count
  // periods of the load, at most one microsecond early
  task wait_exp(input int idx, input int lo, input int hi);
    int n;
    n = 0;
    while ((idx == 0 ? first_guard_timer_expired :
            second_guard_timer_expired) !== 1'b1 && n < hi + 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : wait_exp

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b1, gtw_pkg::T1_RESET_RES, RC));
    acc(1'b0, gtw_pkg::ADDR_CTL2, 4'hf, 32'h0);
    chk(q, mk(1'b1, gtw_pkg::T2_RESET_RES, RC));
    acc(1'b0, gtw_pkg::ADDR_STAT2, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, {16'h0, RC});
    chk({30'h0, first_guard_timer_expired, second_guard_timer_expired},
        32'h0);
  endtask : t_reset

  // bad arming attempts, each followed by a would-be valid second write
  task t_bad_arm;
    logic [3:0] bes [3];
    logic [7:0] keys [3];
    bes = '{4'hc, 4'h8, 4'h9};
    keys = '{8'h55, 8'h56, 8'h55};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, gtw_pkg::ADDR_CTL1, bes[i], {keys[i], 24'h000000});
      acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hf, 32'haa80000c);
      acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
      chk(q, mk(1'b1, gtw_pkg::T1_RESET_RES, RC));
    end
    acc(1'b1, gtw_pkg::ADDR_STAT1, 4'hf, 32'h00000001);
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, {16'h0, RC});
  endtask : t_bad_arm

  task t_prog_expire;
    arm1();
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b1, gtw_pkg::T1_RESET_RES, RC));
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, {16'h0, RC});
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hf, 32'haa80000c);
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0000000c);
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b1, 4'h0, 16'h000c));
    // two reads have used four cycles since the load
    wait_exp(0, 11 * 40 - 4, 12 * 40 - 4);
    repeat (100) @(posedge clk);
    #1;
    chk({31'h0, first_guard_timer_expired}, 32'h1);
    chk({31'h0, second_guard_timer_expired}, 32'h0);
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0);
  endtask : t_prog_expire

  // key lane only: count comes back from the stored reload
  task t_reinit;
    arm1();
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'h8, 32'haa000000);
    chk({31'h0, first_guard_timer_expired}, 32'h0);
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0000000c);
    // one read has used two cycles since the load
    wait_exp(0, 11 * 40 - 2, 12 * 40 - 2);
  endtask : t_reinit

  task t_stop_start;
    arm1();
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hb, 32'haa0f0004);
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b1, 4'h0, 16'h0004));
    arm1();
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hd, 32'haa00ff00);
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b0, 4'h0, 16'h0004));
    repeat (300) @(posedge clk);
    acc(1'b0, gtw_pkg::ADDR_STAT1, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, 32'h00000004);
    // wrong second key spends the arming
    arm1();
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hf, 32'h00800001);
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hf, 32'haa800001);
    acc(1'b0, gtw_pkg::ADDR_CTL1, 4'hf, 32'h0);
    chk(q, mk(1'b0, 4'h0, 16'h0004));
    arm1();
    acc(1'b1, gtw_pkg::ADDR_CTL1, 4'hc, 32'haa800000);
    wait_exp(0, 3 * 40, 4 * 40);
  endtask : t_stop_start

  // second timer on its own; the first stays expired meanwhile
  task t_second;
    acc(1'b1, gtw_pkg::ADDR_CTL2, gtw_pkg::BE_KEY_ONLY, 32'h55000000);
    acc(1'b1, gtw_pkg::ADDR_CTL2, 4'hf, 32'haa800003);
    chk({31'h0, second_guard_timer_expired}, 32'h0);
    wait_exp(1, 2 * 40, 3 * 40);
    chk({31'h0, first_guard_timer_expired}, 32'h1);
    acc(1'b0, gtw_pkg::ADDR_STAT2, 4'hf, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0);
  endtask : t_second

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    reg_req = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 2'h0;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bad_arm();
    t_prog_expire();
    t_reinit();
    t_stop_start();
    t_second();
    close_out();
  end

  // whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule : dual_watchdog_timer_tb_top
